// >>> hw/spief_core.sv
// Overview of operation
// - master detects mode fault on select low
// - fault sets flag, may raise interrupt
// - fault clears port enable, outputs released
// - fault clears master select, unit becomes slave
// - fault flag cleared: status read, control write
// - while faulted, enable and master stay cleared
// - slave never sets fault flag
// - byte done with flag set gives overrun
// - overrun keeps first byte, drops later ones
// - status read clears overrun flag
// - data write while busy dropped, collision set
// - collision in both modes, never interrupts
// - receive buffer read, never the shifter
// - wait mode normal, events wake from wait
// - halt freezes registers and unit unless select low at entry
// - several bytes before halt wake give overrun
// - slave completion wakes device from halt
// - halt wake needs select low at entry
// - three events share one masked request
// - top control bit enables all interrupts
// - done flag cleared: status then data access
// - data writes ignored until status read or write
`timescale 1ns/1ps
`default_nettype none

module spief_core (
    // system
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // spi pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    // cpu power and interrupt
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    output logic irq,
    output logic halt_wake
);

    spief_pkg::spief_state_t r;
    spief_pkg::spief_state_t n;

    logic req;
    logic acc_data;
    logic acc_ctrl;
    logic acc_stat;
    logic wr_lo;
    logic ss_int;
    logic pe;
    logic master_select_bit;
    logic events;
    logic [5:0] half;

    // one access per request; the ack cycle blocks a repeat
    assign req = wb_cyc_i && wb_stb_i && !r.ack;
    assign acc_data = req && (wb_adr_i == spief_pkg::ADR_DATA);
    assign acc_ctrl = req && (wb_adr_i == spief_pkg::ADR_CTRL);
    assign acc_stat = req && (wb_adr_i == spief_pkg::ADR_STAT);
    assign wr_lo = wb_we_i && wb_sel_i[0];

    // internal select from pin or from software level
    assign ss_int = r.stat[spief_pkg::STA_SSM] ? r.stat[spief_pkg::STA_SSI]
                                               : r.sync2[spief_pkg::SY_SS];
    assign pe = r.ctrl[spief_pkg::CTL_PE];
    assign master_select_bit = r.ctrl[spief_pkg::CTL_MASTER_SELECT_BIT];

    // collision flag deliberately left out of the request
    assign events = r.stat[spief_pkg::STA_TDF] | r.stat[spief_pkg::STA_MODE_FAULT_FLAG]
                  | r.stat[spief_pkg::STA_OVR];

    // shared request, also the wait-mode wake source
    assign irq = r.ctrl[spief_pkg::CTL_IE] && events && !cpu_irq_mask;

    // only completion exits halt, and only if selected at entry
    // halt_ok lags the halt level by one cycle, so gate with the live level
    assign halt_wake = r.ctrl[spief_pkg::CTL_IE] && r.stat[spief_pkg::STA_TDF]
                     && !cpu_irq_mask && r.halt_ok && halt_mode;

    // every output released while the port is disabled
    assign sck_o = r.sck_out;
    assign sck_oe = pe && master_select_bit;
    assign mosi_o = r.shift[7];
    assign mosi_oe = pe && master_select_bit && !r.stat[spief_pkg::STA_SOD];
    assign miso_o = r.shift[7];
    assign miso_oe = pe && !master_select_bit && !ss_int && !r.stat[spief_pkg::STA_SOD];
    assign wb_ack_o = r.ack;
    assign wb_dat_o = {24'h000000, r.rdata};

    // master half period from the three rate bits
    always_comb
    begin
        case ({r.ctrl[spief_pkg::CTL_DIV2], r.ctrl[1:0]})
            3'b100: half = spief_pkg::HALF_DIV4;
            3'b000: half = spief_pkg::HALF_DIV8;
            3'b001: half = spief_pkg::HALF_DIV16;
            3'b110: half = spief_pkg::HALF_DIV32;
            3'b010: half = spief_pkg::HALF_DIV64;
            3'b011: half = spief_pkg::HALF_DIV128;
            default: half = spief_pkg::HALF_DIV8;
        endcase
    end

    // next state of the whole block
    always_comb
    begin
        logic sck_lvl;
        logic edge_seen;
        logic sample;
        logic in_bit;
        logic done;
        logic active;
        logic frozen;
        logic [7:0] rx;
        sck_lvl = 1'b0;
        edge_seen = 1'b0;
        sample = 1'b0;
        in_bit = 1'b0;
        done = 1'b0;
        active = 1'b0;
        frozen = halt_mode;
        rx = 8'h00;
        n = r;

        // two-stage synchronisers; stage one feeds only stage two
        n.sync1 = {ss_n_i, miso_i, mosi_i, sck_i};
        n.sync2 = r.sync1;
        n.sck_prev = r.sync2[spief_pkg::SY_SCK];
        n.halt_prev = halt_mode;

        // capture select level as halt is entered
        if (halt_mode && !r.halt_prev)
        begin
            n.halt_ok = !ss_int;
        end
        else if (!halt_mode)
        begin
            n.halt_ok = 1'b0;
        end

        // bus answer one cycle after the request, dropped next
        n.ack = req;

        // read data holds the value before any side effect
        if (req)
        begin
            if (acc_data)
            begin
                n.rdata = r.rxbuf;
            end
            else if (acc_ctrl)
            begin
                n.rdata = r.ctrl;
            end
            else if (acc_stat)
            begin
                n.rdata = r.stat;
            end
            else
            begin
                n.rdata = 8'h00;
            end
        end

        // master clock: toggles at the half period while busy
        if (pe && master_select_bit && r.busy && !frozen)
        begin
            if (r.divcnt == half)
            begin
                n.divcnt = 6'h00;
                n.sck_out = !r.sck_out;
                n.edgecnt = r.edgecnt + 5'h01;
                sample = (r.sck_out == (r.ctrl[spief_pkg::CTL_CPOL]
                          ^ r.ctrl[spief_pkg::CTL_CPHA]));
                if (r.edgecnt == spief_pkg::EDGES_PER_BYTE - 5'h01)
                begin
                    n.busy = 1'b0;
                    n.edgecnt = 5'h00;
                end
            end
            else
            begin
                n.divcnt = r.divcnt + 6'h01;
            end
            in_bit = r.sync2[spief_pkg::SY_MISO];
        end
        else if (pe && !master_select_bit)
        begin
            // slave: edges of the synchronised pin clock
            sck_lvl = r.sync2[spief_pkg::SY_SCK];
            edge_seen = (sck_lvl != r.sck_prev) && !ss_int
                        && (!frozen || r.halt_ok);
            sample = edge_seen && (sck_lvl == !(r.ctrl[spief_pkg::CTL_CPOL]
                     ^ r.ctrl[spief_pkg::CTL_CPHA]));
            in_bit = r.sync2[spief_pkg::SY_MOSI];
            if (ss_int)
            begin
                n.bitcnt = 4'h0;
            end
        end
        if (!master_select_bit || !pe)
        begin
            n.sck_out = r.ctrl[spief_pkg::CTL_CPOL];
        end

        // shift one bit on every sampling edge
        if (sample)
        begin
            rx = {r.shift[6:0], in_bit};
            n.shift = rx;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == spief_pkg::BITS_PER_BYTE - 4'h1)
            begin
                n.bitcnt = 4'h0;
                done = 1'b1;
            end
        end

        // byte complete: buffer it, or flag overrun and drop it
        if (done)
        begin
            if (r.stat[spief_pkg::STA_TDF])
            begin
                n.stat[spief_pkg::STA_OVR] = 1'b1;
            end
            else
            begin
                n.rxbuf = rx;
                n.stat[spief_pkg::STA_TDF] = 1'b1;
            end
        end

        // shifter in use; slave with phase 0 is busy while selected
        active = master_select_bit ? r.busy
                 : (r.bitcnt != 4'h0)
                   || (!ss_int && !r.ctrl[spief_pkg::CTL_CPHA] && pe);

        // bus side effects, refused while halted
        if (req && !frozen)
        begin
            if (acc_stat)
            begin
                if (r.stat[spief_pkg::STA_TDF])
                begin
                    n.seen_tdf = 1'b1;
                end
                if (!wb_we_i)
                begin
                    n.stat[spief_pkg::STA_OVR] = done && r.stat[spief_pkg::STA_TDF];
                    if (r.stat[spief_pkg::STA_MODE_FAULT_FLAG])
                    begin
                        n.seen_mode_fault_flag = 1'b1;
                    end
                    if (r.stat[spief_pkg::STA_WRITE_COLLISION_FLAG])
                    begin
                        n.seen_write_collision_flag = 1'b1;
                    end
                end
                else if (wb_sel_i[0])
                begin
                    n.stat[spief_pkg::STA_SOD] = wb_dat_i[spief_pkg::STA_SOD];
                    n.stat[spief_pkg::STA_SSM] = wb_dat_i[spief_pkg::STA_SSM];
                    n.stat[spief_pkg::STA_SSI] = wb_dat_i[spief_pkg::STA_SSI];
                end
            end
            if (acc_ctrl && wr_lo)
            begin
                n.ctrl = wb_dat_i[7:0];
                if (r.stat[spief_pkg::STA_MODE_FAULT_FLAG] && !r.seen_mode_fault_flag)
                begin
                    n.ctrl[spief_pkg::CTL_PE] = 1'b0;
                    n.ctrl[spief_pkg::CTL_MASTER_SELECT_BIT] = 1'b0;
                end
                else if (r.seen_mode_fault_flag)
                begin
                    n.stat[spief_pkg::STA_MODE_FAULT_FLAG] = 1'b0;
                    n.seen_mode_fault_flag = 1'b0;
                end
            end
            if (acc_data)
            begin
                // done flag clears on any data access after the status access, unless a byte completes in that cycle
                if (r.seen_tdf && !done)
                begin
                    n.stat[spief_pkg::STA_TDF] = 1'b0;
                    n.seen_tdf = 1'b0;
                end
                if (!wb_we_i && r.seen_write_collision_flag)
                begin
                    n.stat[spief_pkg::STA_WRITE_COLLISION_FLAG] = 1'b0;
                    n.seen_write_collision_flag = 1'b0;
                end
                if (wr_lo)
                begin
                    if (r.stat[spief_pkg::STA_TDF] && !r.seen_tdf)
                    begin
                        // inhibited until the status register is read or written
                        n.seen_tdf = 1'b0;
                    end
                    else if (active)
                    begin
                        n.stat[spief_pkg::STA_WRITE_COLLISION_FLAG] = 1'b1;
                        n.seen_write_collision_flag = 1'b0;
                    end
                    else if (!sample)
                    begin
                        n.shift = wb_dat_i[7:0];
                        n.bitcnt = 4'h0;
                        n.busy = pe && master_select_bit;
                        n.divcnt = 6'h00;
                        n.edgecnt = 5'h00;
                    end
                end
            end
        end

        // mode fault: master only, beats any control write
        if (pe && master_select_bit && !ss_int)
        begin
            n.stat[spief_pkg::STA_MODE_FAULT_FLAG] = 1'b1;
            n.ctrl[spief_pkg::CTL_PE] = 1'b0;
            n.ctrl[spief_pkg::CTL_MASTER_SELECT_BIT] = 1'b0;
            n.seen_mode_fault_flag = 1'b0;
            n.busy = 1'b0;
            n.bitcnt = 4'h0;
            n.edgecnt = 5'h00;
        end

        // freeze: registers hold apart from the wake path
        if (frozen && !r.halt_ok)
        begin
            n.ctrl = r.ctrl;
            n.stat = r.stat;
            n.shift = r.shift;
            n.rxbuf = r.rxbuf;
            n.bitcnt = r.bitcnt;
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r <= '{ctrl: spief_pkg::CTRL_RST, stat: spief_pkg::STAT_RST,
                   shift: spief_pkg::DATA_RST, rxbuf: spief_pkg::DATA_RST,
                   bitcnt: 4'h0, edgecnt: 5'h00, divcnt: 6'h00, busy: 1'b0,
                   sck_out: 1'b0, seen_tdf: 1'b0, seen_mode_fault_flag: 1'b0,
                   seen_write_collision_flag: 1'b0, sync1: 4'h8, sync2: 4'h8, sck_prev: 1'b0,
                   halt_prev: 1'b0, halt_ok: 1'b0, ack: 1'b0, rdata: 8'h00};
        end
        else
        begin
            r <= n;
        end
    end

endmodule : spief_core

`default_nettype wire

// >>> hw/spief_pkg.sv
package spief_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA = 8'h31;
    localparam logic [7:0] IDX_CTRL = 8'h32;
    localparam logic [7:0] IDX_STAT = 8'h33;
    localparam logic [9:0] ADR_DATA = {IDX_DATA, 2'b00};
    localparam logic [9:0] ADR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADR_STAT = {IDX_STAT, 2'b00};

    // control register bit positions
    localparam int CTL_IE = 7;
    localparam int CTL_PE = 6;
    localparam int CTL_DIV2 = 5;
    localparam int CTL_MASTER_SELECT_BIT = 4;
    localparam int CTL_CPOL = 3;
    localparam int CTL_CPHA = 2;

    // status register bit positions
    localparam int STA_TDF = 7;
    localparam int STA_WRITE_COLLISION_FLAG = 6;
    localparam int STA_OVR = 5;
    localparam int STA_MODE_FAULT_FLAG = 4;
    localparam int STA_SOD = 2;
    localparam int STA_SSM = 1;
    localparam int STA_SSI = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // synchroniser lanes
    localparam int SY_SCK = 0;
    localparam int SY_MOSI = 1;
    localparam int SY_MISO = 2;
    localparam int SY_SS = 3;

    // master sck: half period in clk cycles minus one, per rate code
    localparam logic [5:0] HALF_DIV4 = 6'h01;
    localparam logic [5:0] HALF_DIV8 = 6'h03;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV32 = 6'h0f;
    localparam logic [5:0] HALF_DIV64 = 6'h1f;
    localparam logic [5:0] HALF_DIV128 = 6'h3f;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

    // whole block state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] shift;
        logic [7:0] rxbuf;
        logic [3:0] bitcnt;
        logic [4:0] edgecnt;
        logic [5:0] divcnt;
        logic busy;
        logic sck_out;
        logic seen_tdf;
        logic seen_mode_fault_flag;
        logic seen_write_collision_flag;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic sck_prev;
        logic halt_prev;
        logic halt_ok;
        logic ack;
        logic [7:0] rdata;
    } spief_state_t;

endpackage : spief_pkg

// >>> tb/spief_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module spief_monitor (
    // system
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // pins
    input wire logic ss_n_i,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    // cpu side
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    input wire logic irq,
    input wire logic halt_wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // request and halt wake-up are gated by the cpu mask
    property p_irq_mask; irq |-> !cpu_irq_mask; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_wake_irq; halt_wake |-> irq && halt_mode; endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("wake without request");
    // master with select low must give up the pins within a few cycles
    property p_fault_release; not ((!ss_n_i && sck_oe) [*5]); endproperty
    a_fault_release: assert property (p_fault_release) else $error("fault kept");
    // after a fault the unit is disabled, so no slave output either
    property p_fault_drop; $fell(sck_oe) && !ss_n_i |-> !miso_oe [*4]; endproperty
    a_fault_drop: assert property (p_fault_drop) else $error("fault left enable");
    property p_roles; mosi_oe |-> sck_oe && !miso_oe; endproperty
    a_roles: assert property (p_roles) else $error("master and slave outputs");
    // bus answers one cycle after a request, as a single pulse
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    // reset has its own check, so it cannot be disabled by itself
    property p_reset; disable iff (1'b0) rst |=> !irq && !sck_oe && !mosi_oe && !wb_ack_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active after reset");

    c_fault: cover property ($fell(sck_oe) && !ss_n_i);
    c_wake: cover property ($rose(halt_wake));
    c_irq: cover property ($rose(irq) && !halt_mode);
endmodule : spief_monitor

bind spief_core spief_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ss_n_i(ss_n_i), .sck_oe(sck_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .halt_mode(halt_mode),
    .cpu_irq_mask(cpu_irq_mask), .irq(irq), .halt_wake(halt_wake));

`default_nettype wire

// >>> tb/spief_partner.sv
`timescale 1ns/1ps
`default_nettype none

module spief_partner (
    // into the device
    output logic sck_p,
    output logic mosi_p,
    output logic ss_n_p,
    output logic miso_p,
    // from the device
    input wire logic sck_d,
    input wire logic sck_de,
    input wire logic mosi_d,
    input wire logic miso_d,
    input wire logic miso_de,
    // bytes taken in as slave
    output logic [7:0] heard,
    // bytes taken in as master
    output logic [7:0] echo
);
    logic [7:0] reply = 8'h3c;
    wire mosi_dly;

    initial
    begin
        sck_p = 1'b0;
        mosi_p = 1'b0;
        ss_n_p = 1'b1;
        heard = 8'h00;
        echo = 8'h00;
    end
    // delayed copy: device moves mosi on the same edge as sck
    assign #1 mosi_dly = mosi_d;
    // slave role: fixed reply rotated back to itself each byte
    assign miso_p = reply[7];
    always @(negedge sck_d) if (sck_de) reply <= {reply[6:0], reply[7]};
    always @(posedge sck_d) if (sck_de) heard <= {heard[6:0], mosi_dly};

    // select level, kept off the device clock edges
    task automatic sel(input logic lvl);
        #2 ss_n_p = lvl;
    endtask : sel

    // master role: idle-low clock, first edge samples, 80 ns period
    task automatic xfer(input logic [7:0] tx);
        #2 ss_n_p = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_p = tx[i];
            #40 sck_p = 1'b1;
            // a released miso line reads as the wrong bit
            echo = {echo[6:0], miso_de ? miso_d : ~miso_d};
            #40 sck_p = 1'b0;
        end
        #40 ss_n_p = 1'b1;
        mosi_p = ~mosi_p; // released line must not keep its last bit
        #80;
    endtask : xfer
endmodule : spief_partner

`default_nettype wire

// >>> tb/test_spief_core.sv
`timescale 1ns/1ps
`default_nettype none

module test_spief_core;
    localparam logic [9:0] AD = spief_pkg::ADR_DATA;
    localparam logic [9:0] AC = spief_pkg::ADR_CTRL;
    localparam logic [9:0] AS = spief_pkg::ADR_STAT;
    typedef struct packed { logic [9:0] a; logic [7:0] w; logic [7:0] r; } spief_row_t;
    logic clk, rst, cyc, stb, we, halt, mask;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic ack, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, ss_n;
    logic irq, wake;
    logic [7:0] heard, echo, q;
    int errors = 0, cmp_count = 0;
    // data reads the receive buffer, status keeps only its writable bits
    spief_row_t rows [4] = '{'{AD, 8'h5a, 8'h00}, '{AC, 8'h2c, 8'h2c},
        '{AS, 8'hff, 8'h07}, '{10'h100, 8'hff, 8'h00}};

    always #5 clk = ~clk;

    spief_core DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_n_i(ss_n), .halt_mode(halt), .cpu_irq_mask(mask), .irq(irq), .halt_wake(wake));
    spief_partner u_far (.sck_p(sck_i), .mosi_p(mosi_i), .ss_n_p(ss_n), .miso_p(miso_i),
        .sck_d(sck_o), .sck_de(sck_oe), .mosi_d(mosi_o), .miso_d(miso_o),
        .miso_de(miso_oe), .heard(heard), .echo(echo));

    task automatic end_sim;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic cycle held until ack is sampled, then released
    task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                errors++;
                end_sim();
            end
            @(posedge clk);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        chk(q, e);
    endtask : rd

    // bounded wait on the request line, or on halt wake-up
    task automatic wfor(input logic hw);
        int n;
        n = 0;
        while ((hw ? wake : irq) !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n > 400)
            begin
                errors++;
                end_sim();
            end
        end
    endtask : wfor

    initial
    begin
        clk = 1'b0;
        rst <= 1'b1;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        halt <= 1'b0;
        mask <= 1'b0;
        adr <= 10'h000;
        sel <= 4'h0;
        wdat <= 32'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            rd(rows[i].a, 8'h00);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        // a write without the low byte lane changes nothing
        bus(AC, 1'b1, 8'h00, 4'he);
        rd(AC, 8'h2c);
        // reset in mid-run clears what the table left behind
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(AS, 8'h00);
        // master byte; a second write during the shift collides
        wr(AC, 8'hd0);
        wr(AD, 8'ha5);
        wr(AD, 8'h99);
        chk({7'h0, irq}, 8'h00);
        wfor(1'b0);
        chk(heard, 8'ha5);
        rd(AS, 8'hc0);
        rd(AD, 8'h3c);
        rd(AS, 8'h00);
        // with the done flag up a data write starts nothing
        wr(AD, 8'h0f);
        wfor(1'b0);
        wr(AD, 8'h77);
        repeat (80) @(posedge clk);
        chk(heard, 8'h0f);
        rd(AS, 8'h80);
        rd(AD, 8'h3c);
        // select pulled low under a master
        u_far.sel(1'b0);
        wfor(1'b0);
        rd(AC, 8'h80);
        mask <= 1'b1;
        @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        mask <= 1'b0;
        wr(AC, 8'h00);
        chk({7'h0, irq}, 8'h00);
        u_far.sel(1'b1);
        wr(AC, 8'hd0);
        rd(AC, 8'h80);
        rd(AS, 8'h10);
        wr(AC, 8'h80);
        rd(AS, 8'h00);
        // slave: second byte lands before the flag is cleared
        wr(AC, 8'hc0);
        wr(AD, 8'hc3);
        u_far.xfer(8'h11);
        chk(echo, 8'hc3);
        u_far.xfer(8'h22);
        chk(echo, 8'h11);
        chk({7'h0, irq}, 8'h01);
        rd(AS, 8'ha0);
        rd(AD, 8'h11);
        rd(AS, 8'h00);
        // halt entered with select low, then with select high
        for (int k = 0; k < 2; k++)
        begin
            u_far.sel(k[0]);
            repeat (4) @(posedge clk);
            halt <= 1'b1;
            u_far.xfer(8'h5a);
            u_far.xfer(8'h5a);
            chk({7'h0, wake}, {7'h0, ~k[0]});
            @(posedge clk);
            halt <= 1'b0;
            rd(AS, k[0] ? 8'h00 : 8'ha0);
            rd(AD, k[0] ? 8'h00 : 8'h5a);
            // one more byte while still slave brings the port back to normal
            u_far.xfer(8'h00);
            rd(AS, 8'h80);
            rd(AD, 8'h00);
        end
        end_sim();
    end
endmodule : test_spief_core

`default_nettype wire
